// >>> core/uswc_defs.vh
// constants for the usb suspend and wake control block
// Operation
// RULE1: shallow depth accepts gpio, wake frame and addressed wake frame wakeups.
// RULE2: shallow depth stops mac and module clocks while suspended.
// RULE3: middle depth accepts only gpio and link change; lower power than shallow.
// RULE4: deep depth accepts only gpio assertion as wakeup source.
// RULE5: after reset suspend depth is the deep depth.
// RULE6: every gpio pin may serve as a wakeup source while suspended.
// RULE7: software enables whether each ethernet wake event raises remote wakeup.
// RULE8: depth is software writable; unsupported sources are ignored.
`ifndef USWC_DEFS_VH
`define USWC_DEFS_VH
`define USWC_DEPTH_SHALLOW 2'h0
`define USWC_DEPTH_MIDDLE  2'h1
`define USWC_DEPTH_DEEP    2'h2
`define USWC_DEPTH_RESET   2'h2
`define USWC_ST_AWAKE      2'h0
`define USWC_ST_SUSP       2'h1
`define USWC_ST_WAKE       2'h2
`define USWC_WAKE_PULSE_NS 1000
`define USWC_CLK_NS        100
`define USWC_WAKE_CYC ((`USWC_WAKE_PULSE_NS + `USWC_CLK_NS - 1) / `USWC_CLK_NS)
`endif

// >>> core/uswc_sync.v
// two flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module uswc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_sys_clk,
  input  wire             i_arst_n,
  // data
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;
  // first stage feeds only the second
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end else begin
      meta   <= i_async;
      stable <= meta;
    end
  end
  assign o_sync = stable;
endmodule // uswc_sync

// >>> core/uswc_top.v
// usb suspend depth selection and remote wakeup source gating
`timescale 1ns/1ps
`include "uswc_defs.vh"
module uswc_top #(
  parameter GPIO_W   = 8,
  parameter WAKE_CYC = `USWC_WAKE_CYC
) (
  // clock and reset
  input  wire              i_sys_clk,
  input  wire              i_arst_n,
  // configuration from software
  input  wire [1:0]        i_depth_sel,
  input  wire              i_depth_load,
  input  wire [GPIO_W-1:0] i_gpio_wake_en,
  input  wire              i_wake_frame_en,
  input  wire              i_addr_frame_en,
  input  wire              i_link_chg_en,
  // usb suspend state from the upstream port
  input  wire              i_suspend,
  // wake sources
  input  wire [GPIO_W-1:0] i_gpio,
  input  wire              i_wake_frame_detect,
  input  wire              i_addr_frame_detect,
  input  wire              i_link_chg,
  // status and controls
  output reg  [1:0]        o_depth,
  output reg               o_mac_clk_stop,
  output reg               o_module_clk_stop,
  output reg               o_phy_power_down,
  output reg               o_remote_wake,
  output reg  [3:0]        o_wake_cause
);

  // synchronised pins and their edge history
  wire [GPIO_W-1:0] gpio_s;
  reg  [GPIO_W-1:0] gpio_d;
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [15:0]       cnt;
  reg               susp_d;
  wire              gpio_hit;
  wire              wf_hit;
  wire              af_hit;
  wire              lc_hit;
  wire              any_hit;

  // wake sources as {link, addr, frame, gpio}
  wire [3:0]        src_raw;
  wire [3:0]        src_en;
  wire [3:0]        src_mask;
  wire [3:0]        src_hit;
  // last count of the wake pulse timer
  localparam [31:0] WAKE_LAST = WAKE_CYC - 1;

  // returns 1 when a depth value names a defined depth
  function depth_ok;
    input [1:0] d;
    begin
      depth_ok = (d == `USWC_DEPTH_SHALLOW) || (d == `USWC_DEPTH_MIDDLE) ||
                 (d == `USWC_DEPTH_DEEP);
    end
  endfunction

  // wake sources each depth admits, as {link, addr, frame, gpio}
  function [3:0] depth_mask;
    input [1:0] d;
    begin
      case (d)
        `USWC_DEPTH_SHALLOW: begin
          depth_mask = 4'h7; // RULE1
        end
        `USWC_DEPTH_MIDDLE: begin
          depth_mask = 4'h9; // RULE3
        end
        `USWC_DEPTH_DEEP: begin
          depth_mask = 4'h1; // RULE4
        end
        default: begin
          depth_mask = 4'h1;
        end
      endcase
    end
  endfunction

  // gpio pins come from outside and are synchronised first
  uswc_sync #(
    .WIDTH (GPIO_W)
  ) u_gpio_sync (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (i_gpio),
    .o_sync    (gpio_s)
  );

  // depth setting, deep after reset, undefined values ignored
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_depth <= `USWC_DEPTH_RESET; // RULE5
    end else if (i_depth_load && depth_ok(i_depth_sel)) begin
      o_depth <= i_depth_sel; // RULE8
    end
  end

  // gpio rising edge of an enabled synchronised pin counts as assertion
  assign gpio_hit = |(gpio_s & ~gpio_d & i_gpio_wake_en); // RULE6 RULE4

  // raw events of every source, same clock as this block
  assign src_raw  = {i_link_chg, i_addr_frame_detect,
                     i_wake_frame_detect, gpio_hit};
  // software enables for the ethernet wake events
  assign src_en   = {i_link_chg_en, i_addr_frame_en,
                     i_wake_frame_en, 1'b1}; // RULE7
  // the selected depth masks out the sources it does not support
  assign src_mask = depth_mask(o_depth); // RULE8
  assign src_hit  = src_raw & src_en & src_mask; // RULE1 RULE3 RULE4

  // per source hits, kept by name for the state machine
  assign wf_hit   = src_hit[1];
  assign af_hit   = src_hit[2];
  assign lc_hit   = src_hit[3];
  assign any_hit  = src_hit[0] | wf_hit | af_hit | lc_hit;

  // suspend state machine: awake, suspended, then a timed wake pulse;
  // entry needs a fresh rise of the suspend level, so a host that stays
  // suspended through a wake does not re-enter until it drops and rises
  always @* begin
    next_state = state;
    case (state)
      `USWC_ST_AWAKE: begin
        if (i_suspend && !susp_d) begin
          next_state = `USWC_ST_SUSP;
        end
      end
      `USWC_ST_SUSP: begin
        if (!i_suspend) begin
          next_state = `USWC_ST_AWAKE;
        end else if (any_hit) begin
          next_state = `USWC_ST_WAKE;
        end
      end
      `USWC_ST_WAKE: begin
        if ({16'h0000, cnt} == WAKE_LAST) begin
          next_state = `USWC_ST_AWAKE;
        end
      end
      default: begin
        next_state = `USWC_ST_AWAKE;
      end
    endcase
  end

  // state register
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= `USWC_ST_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  // edge history of the synchronised pins and of the suspend level
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gpio_d <= {GPIO_W{1'b0}};
      susp_d <= 1'b0;
    end else begin
      gpio_d <= gpio_s;
      susp_d <= i_suspend;
    end
  end

  // wake pulse timer, counts only while the wake pulse stands
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 16'h0000;
    end else if (state == `USWC_ST_WAKE) begin
      cnt <= cnt + 16'h0001;
    end else begin
      cnt <= 16'h0000;
    end
  end

  // cause of the last wake, only when a wake really starts; held after
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake_cause <= 4'h0;
    end else if (state == `USWC_ST_SUSP && i_suspend && any_hit) begin
      o_wake_cause <= src_hit;
    end
  end

  // remote wakeup signalling toward the upstream host
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_remote_wake <= 1'b0;
    end else begin
      o_remote_wake <= (next_state == `USWC_ST_WAKE);
    end
  end

  // every depth stops the mac and module clocks while suspended
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mac_clk_stop    <= 1'b0;
      o_module_clk_stop <= 1'b0;
    end else begin
      o_mac_clk_stop    <= (next_state == `USWC_ST_SUSP); // RULE2
      o_module_clk_stop <= (next_state == `USWC_ST_SUSP); // RULE2
    end
  end

  // middle and deep also cut phy power, for less draw than shallow
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_phy_power_down <= 1'b0;
    end else begin
      o_phy_power_down <= (next_state == `USWC_ST_SUSP) &&
                          (o_depth != `USWC_DEPTH_SHALLOW); // RULE3
    end
  end
endmodule // uswc_top

// >>> testbench/uswc_host.sv
// upstream host model: suspends on request, resumes on remote wakeup
`timescale 1ns/1ps
module uswc_host (
  input  wire i_sys_clk,
  input  wire i_arst_n,
  input  wire i_want,
  input  wire i_remote_wake,
  output reg  o_suspend
);
  // a remote wakeup resumes the bus on the next clock
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_suspend <= 1'h0;
    else o_suspend <= i_want & ~i_remote_wake;
  end
endmodule // uswc_host

// >>> testbench/uswc_props.sv
// assertions for suspend depth and remote wakeup
`timescale 1ns/1ps
module uswc_props #(parameter WAKE_CYC = 10) (
  input logic       i_sys_clk, i_arst_n, i_depth_load, i_suspend,
  input logic [1:0] i_depth_sel, o_depth,
  input logic       i_wake_frame_detect, i_wake_frame_en, i_link_chg,
  input logic       i_link_chg_en, o_mac_clk_stop, o_module_clk_stop,
  input logic       o_phy_power_down, o_remote_wake,
  input logic [3:0] o_wake_cause
);
  int cnt;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // length of the running wake pulse
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
    if (!i_arst_n) cnt <= 0;
    else cnt <= o_remote_wake ? cnt + 1 : 0;
  sequence s_asleep; i_suspend && o_mac_clk_stop && !o_remote_wake; endsequence
  a_depth_load: assert property (i_depth_load && i_depth_sel != 2'h3
    |=> o_depth == $past(i_depth_sel)) else $error("depth not loaded");
  a_depth_hold: assert property (!i_depth_load |=> $stable(o_depth))
    else $error("depth moved");
  a_frame_wake: assert property (s_asleep ##0 (i_wake_frame_detect
    && i_wake_frame_en && o_depth == 2'h0) |=> o_remote_wake && o_wake_cause[1])
    else $error("frame wake lost");
  a_link_wake: assert property (s_asleep ##0 (i_link_chg && i_link_chg_en
    && o_depth == 2'h1) |=> o_remote_wake && o_wake_cause[3])
    else $error("link wake lost");
  a_deep_cause: assert property ($rose(o_remote_wake) && o_depth == 2'h2
    |-> o_wake_cause == 4'h1) else $error("deep wake not gpio");
  a_frame_gate: assert property ($rose(o_remote_wake) && o_wake_cause[1]
    |-> $past(i_wake_frame_en)) else $error("disabled frame woke");
  a_wake_origin: assert property ($rose(o_remote_wake)
    |-> $past(o_mac_clk_stop) && !o_mac_clk_stop) else $error("bad wake");
  a_clk_stop: assert property ($rose(i_suspend) && !o_remote_wake
    |=> o_mac_clk_stop && o_module_clk_stop) else $error("clocks run");
  a_phy_down: assert property (o_phy_power_down
    |-> o_mac_clk_stop && o_depth != 2'h0) else $error("phy down wrong");
  a_pulse_len: assert property ($fell(o_remote_wake) |-> cnt == WAKE_CYC)
    else $error("wake pulse length");
endmodule // uswc_props
bind uswc_top uswc_props #(.WAKE_CYC(WAKE_CYC)) u_props (.*);

// >>> testbench/testbench.sv
// self-checking bench for suspend depth and remote wakeup
`timescale 1ns/1ps
module testbench;
  logic       i_sys_clk = 0, i_arst_n = 0, i_depth_load = 0, i_suspend;
  logic [1:0] i_depth_sel = 0, o_depth;
  logic [7:0] i_gpio_wake_en = 8'hFF, i_gpio = 0;
  logic       want = 0, i_wake_frame_en = 0, i_addr_frame_en = 0;
  logic       i_link_chg_en = 0, i_wake_frame_detect = 0;
  logic       i_addr_frame_detect = 0, i_link_chg = 0, o_remote_wake;
  logic       o_mac_clk_stop, o_module_clk_stop, o_phy_power_down;
  logic [3:0] o_wake_cause;
  int         n_errors = 0, total_checks = 0, cyc = 0;
  uswc_top #(.WAKE_CYC(2)) dut (.*);
  uswc_host u_host (.i_sys_clk, .i_arst_n, .i_want(want),
    .i_remote_wake(o_remote_wake), .o_suspend(i_suspend));
  always #50 i_sys_clk = ~i_sys_clk;
  // cut a hang short
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin n_errors++; conclude(); end
  end
  task step; @(posedge i_sys_clk) #10; endtask
  task chk(input string nm, input [3:0] seen, input [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one suspend, one stimulus, then resume
  task run(input [1:0] d, input [3:0] s, input [7:0] g, input en,
           input [3:0] e);
    reg w;
    w = 0; i_depth_sel = d; i_depth_load = 1; step; i_depth_load = 0;
    {i_wake_frame_en, i_addr_frame_en, i_link_chg_en} = {3{en}};
    want = 1; repeat (3) step; chk("clk_stop", o_mac_clk_stop, 1);
    chk("mod_stop", o_module_clk_stop, 1);
    chk("phy_down", o_phy_power_down, d != 0);
    {i_link_chg, i_addr_frame_detect, i_wake_frame_detect} = s[3:1];
    i_gpio = g; step; {i_link_chg, i_addr_frame_detect, i_wake_frame_detect} = 0;
    repeat (6) begin step; w = w | o_remote_wake; end
    chk("woke", w, e != 0);
    if (e != 0) chk("cause", o_wake_cause, e);
    want = 0; i_gpio = 0; repeat (5) step;
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) step; i_arst_n = 1; step;
    chk("depth", o_depth, 2);
    run(0, 4'h2, 0, 1, 2);
    run(0, 4'h4, 0, 1, 4);
    run(0, 4'h2, 0, 0, 0);
    run(0, 4'h8, 0, 1, 0);
    run(1, 4'h8, 0, 1, 8);
    run(1, 4'h2, 0, 1, 0);
    run(1, 0, 8'h80, 1, 1);
    i_gpio_wake_en = 8'h7F;
    run(1, 0, 8'h80, 1, 0);
    i_gpio_wake_en = 8'hFF;
    run(2, 4'hE, 0, 1, 0);
    run(2, 0, 8'h01, 1, 1);
    i_depth_sel = 3; i_depth_load = 1; step; i_depth_load = 0; step;
    chk("depth", o_depth, 2);
    conclude();
  end
endmodule // testbench
